// ---- sdh_pkg.sv ----
package sdh_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_UI = 12'h008;
    localparam logic [11:0] ADDR_SEG = 12'h00c;
    localparam int CTRL_LIMIT_LSB = 0;
    localparam logic [1:0] CTRL_LIMIT_RESET = 2'h0;
    localparam logic [1:0] LIMIT_FULL = 2'h2;
    localparam int UI_ITEM_LSB = 0;
    localparam int UI_MENU_LSB = 4;
    localparam int UI_MODE_LSB = 8;
    // ****************************************
    // status word layout
    // ****************************************
    localparam int ST_BUSY = 15;
    localparam int ST_LINK = 12;
    localparam int ST_ALARM = 11;
    localparam int ST_SLOW = 10;
    localparam int ST_SPEED = 9;
    localparam int ST_ILIM = 8;
    localparam int ST_VLIM = 7;
    localparam int ST_BUSOK = 5;
    localparam int ST_STOP = 3;
    localparam int ST_BRAKE = 2;
    localparam int ST_REV = 1;
    localparam int ST_FWD = 0;
    localparam logic [15:0] ST_ZERO_MASK = 16'h6050;
    localparam logic [15:0] ST_RESET = 16'h0000;
    // ****************************************
    // menus and items
    // ****************************************
    localparam logic [2:0] MENU_FIRST = 3'h1;
    localparam logic [2:0] MENU_DRIVE = 3'h3;
    localparam logic [2:0] MENU_IO = 3'h4;
    localparam logic [2:0] MENU_LAST = 3'h5;
    localparam logic [3:0] ITEM_STATUS = 4'h7;
    localparam logic [3:0] IO_DIG = 4'h0;
    localparam logic [3:0] IO_LINK = 4'h1;
    localparam logic [3:0] IO_VOLT = 4'h2;
    localparam logic [3:0] IO_CURR = 4'h3;
    localparam logic [3:0] IO_METER = 4'h4;
    localparam logic [4:0] GLY_UNDER = 5'h10;
    localparam logic [4:0] GLY_BLANK = 5'h11;
    localparam logic [4:0] GLY_DASH = 5'h12;

    typedef enum logic [1:0] {MODE_RUN, MODE_MENU, MODE_LIST, MODE_ITEM} sdh_mode_t;
    typedef logic [4:0] sdh_glyph_t;
    typedef logic [6:0] sdh_seg_t;

    // segments {g,f,e,d,c,b,a}, lit high
    function automatic sdh_seg_t sdh_glyph(input sdh_glyph_t g);
        case (g)
            5'h00: return 7'h3f;
            5'h01: return 7'h06;
            5'h02: return 7'h5b;
            5'h03: return 7'h4f;
            5'h04: return 7'h66;
            5'h05: return 7'h6d;
            5'h06: return 7'h7d;
            5'h07: return 7'h07;
            5'h08: return 7'h7f;
            5'h09: return 7'h6f;
            5'h0a: return 7'h77;
            5'h0b: return 7'h7c;
            5'h0c: return 7'h39;
            5'h0d: return 7'h5e;
            5'h0e: return 7'h79;
            5'h0f: return 7'h71;
            5'h10: return 7'h08;
            5'h12: return 7'h40;
            default: return 7'h00;
        endcase
    endfunction
endpackage

// ---- sdh_ui_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sdh_ui_if;
    import sdh_pkg::*;
    logic key_prog;
    logic key_func;
    logic key_up;
    logic key_down;
    sdh_glyph_t [3:0] code;
    sdh_seg_t [3:0] seg;
    modport keys (output key_prog, output key_func, output key_up, output key_down);
    modport dec (input code, output seg);
    modport top (input key_prog, input key_func, input key_up, input key_down,
                 input seg, output code);
endinterface
`default_nettype wire

// ---- sdh_key_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdh_key_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] key_raw,
    sdh_ui_if.keys ui
);
    import sdh_pkg::*;
    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;

    // keys are asynchronous pins: two flops, then a press edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 4'h0;
            sync <= 4'h0;
            prev <= 4'h0;
        end
        else
        begin
            meta <= key_raw;
            sync <= meta;
            prev <= sync;
        end
    end

    assign ui.key_prog = sync[0] & ~prev[0];
    assign ui.key_func = sync[1] & ~prev[1];
    assign ui.key_up = sync[2] & ~prev[2];
    assign ui.key_down = sync[3] & ~prev[3];
endmodule
`default_nettype wire

// ---- sdh_hex_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdh_hex_dec (
    sdh_ui_if.dec ui
);
    import sdh_pkg::*;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ui.seg[i] = sdh_glyph(ui.code[i]);
        end
    end
endmodule
`default_nettype wire

// ---- sdh_status_display.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdh_status_display (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_write_busy,
    input wire logic link_cmd_enabled,
    input wire logic alarm_flag,
    input wire logic slowing_flag,
    input wire logic speeding_flag,
    input wire logic current_limit_flag,
    input wire logic voltage_limit_flag,
    input wire logic bus_voltage_ok,
    input wire logic stage_stopped_flag,
    input wire logic dc_brake_flag,
    input wire logic run_backward_flag,
    input wire logic run_ahead_flag,
    input wire logic [15:0] io_terminals,
    input wire logic [15:0] link_terminals,
    input wire logic [15:0] voltage_analog_in,
    input wire logic [15:0] current_analog_in,
    input wire logic [15:0] meter_analog_out,
    input wire logic [3:0] key_raw,
    output var sdh_pkg::sdh_seg_t [3:0] digit_seg
);
    import sdh_pkg::*;

    sdh_ui_if ui ();

    logic [1:0] ctrl_limit;
    logic [15:0] status_word;
    logic [15:0] next_status;
    sdh_mode_t mode;
    logic [2:0] menu_no;
    logic [3:0] item_no;
    logic [15:0] shown;
    logic ctrl_write;
    logic setup;
    logic access;
    logic [31:0] rd_mux;

    // ****************************************
    // leaves
    // ****************************************
    sdh_key_sync u_keys (
        .pclk(pclk),
        .presetn(presetn),
        .key_raw(key_raw),
        .ui(ui.keys)
    );

    sdh_hex_dec u_dec (
        .ui(ui.dec)
    );

    // ****************************************
    // apb slave
    // ****************************************
    function automatic logic addr_hit(input logic [11:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_UI) || (a == ADDR_SEG);
    endfunction

    assign setup = psel & ~penable;
    assign access = psel & penable;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access & ~addr_hit(paddr);
    assign ctrl_write = access & pwrite & (paddr == ADDR_CTRL);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_limit <= CTRL_LIMIT_RESET;
        end
        else if (ctrl_write)
        begin
            ctrl_limit <= pwdata[CTRL_LIMIT_LSB +: 2];
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL: rd_mux[CTRL_LIMIT_LSB +: 2] = ctrl_limit;
            ADDR_STATUS: rd_mux[15:0] = status_word;
            ADDR_UI:
            begin
                rd_mux[UI_ITEM_LSB +: 4] = item_no;
                rd_mux[UI_MENU_LSB +: 3] = menu_no;
                rd_mux[UI_MODE_LSB +: 2] = mode;
            end
            ADDR_SEG: rd_mux[27:0] = digit_seg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup && !pwrite)
        begin
            prdata <= rd_mux;
        end
    end

    // ****************************************
    // running status word
    // ****************************************
    always_comb
    begin
        next_status = ST_RESET;
        next_status[ST_BUSY] = cfg_write_busy | ctrl_write;
        next_status[ST_LINK] = link_cmd_enabled;
        next_status[ST_ALARM] = alarm_flag;
        next_status[ST_SLOW] = slowing_flag;
        next_status[ST_SPEED] = speeding_flag;
        next_status[ST_ILIM] = current_limit_flag;
        next_status[ST_VLIM] = voltage_limit_flag;
        next_status[ST_BUSOK] = bus_voltage_ok;
        next_status[ST_STOP] = stage_stopped_flag;
        next_status[ST_BRAKE] = dc_brake_flag;
        next_status[ST_REV] = run_backward_flag;
        next_status[ST_FWD] = run_ahead_flag;
    end

    // one register stage keeps the decoders off the raw core flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_word <= ST_RESET;
        end
        else
        begin
            status_word <= next_status & ~ST_ZERO_MASK;
        end
    end

    // ****************************************
    // keypad menu
    // ****************************************
    // return key beats select, which beats the arrows, in one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= MODE_RUN;
            menu_no <= MENU_FIRST;
            item_no <= IO_DIG;
        end
        else
        begin
            unique case (mode)
                MODE_RUN:
                begin
                    if (ui.key_prog)
                    begin
                        mode <= MODE_MENU;
                    end
                end
                MODE_MENU:
                begin
                    if (ui.key_prog)
                    begin
                        mode <= MODE_RUN;
                    end
                    else if (ui.key_func)
                    begin
                        // only the two monitor menus are built here
                        if (ctrl_limit == LIMIT_FULL && menu_no == MENU_IO)
                        begin
                            mode <= MODE_LIST;
                            item_no <= IO_DIG;
                        end
                        else if (ctrl_limit == LIMIT_FULL && menu_no == MENU_DRIVE)
                        begin
                            mode <= MODE_LIST;
                            item_no <= ITEM_STATUS;
                        end
                    end
                    else if (ui.key_up)
                    begin
                        menu_no <= (menu_no == MENU_LAST) ? MENU_FIRST : menu_no + 3'h1;
                    end
                    else if (ui.key_down)
                    begin
                        menu_no <= (menu_no == MENU_FIRST) ? MENU_LAST : menu_no - 3'h1;
                    end
                end
                MODE_LIST:
                begin
                    if (ui.key_prog)
                    begin
                        mode <= MODE_MENU;
                    end
                    else if (ui.key_func)
                    begin
                        mode <= MODE_ITEM;
                    end
                    else if (menu_no == MENU_IO && ui.key_up)
                    begin
                        item_no <= (item_no == IO_METER) ? IO_DIG : item_no + 4'h1;
                    end
                    else if (menu_no == MENU_IO && ui.key_down)
                    begin
                        item_no <= (item_no == IO_DIG) ? IO_METER : item_no - 4'h1;
                    end
                end
                MODE_ITEM:
                begin
                    if (ui.key_prog)
                    begin
                        mode <= MODE_LIST;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // display content
    // ****************************************
    always_comb
    begin
        shown = status_word;
        if (menu_no == MENU_IO)
        begin
            unique case (item_no)
                IO_DIG: shown = io_terminals;
                IO_LINK: shown = link_terminals;
                IO_VOLT: shown = voltage_analog_in;
                IO_CURR: shown = current_analog_in;
                IO_METER: shown = meter_analog_out;
                default: shown = 16'h0000;
            endcase
        end
        else
        begin
            shown = status_word;
        end
    end

    always_comb
    begin
        ui.code = {4{GLY_BLANK}};
        unique case (mode)
            MODE_RUN:
            begin
                for (int i = 0; i < 4; i++)
                begin
                    ui.code[i] = {1'b0, status_word[4*i +: 4]};
                end
            end
            MODE_MENU:
            begin
                ui.code = {{2'b00, menu_no}, GLY_UNDER, GLY_DASH, GLY_DASH};
            end
            MODE_LIST:
            begin
                ui.code = {{2'b00, menu_no}, GLY_UNDER, 5'h00, {1'b0, item_no}};
            end
            MODE_ITEM:
            begin
                for (int i = 0; i < 4; i++)
                begin
                    ui.code[i] = {1'b0, shown[4*i +: 4]};
                end
            end
        endcase
    end

    // segment pins come from flops to keep glitches off the digits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            digit_seg <= '0;
        end
        else
        begin
            digit_seg <= ui.seg;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_item_ret;
        mode == MODE_ITEM && ui.key_prog;
    endsequence

    sequence s_list_ret;
        mode == MODE_LIST && ui.key_prog;
    endsequence

    property p_zero_bits;
        (status_word & ST_ZERO_MASK) == 16'h0000;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved status bit set");

    property p_busy;
        cfg_write_busy |=> status_word[ST_BUSY] ##1 (status_word[ST_BUSY] || !$past(cfg_write_busy));
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit missed a write");

    property p_busy_clear;
        !cfg_write_busy && !ctrl_write |=> !status_word[ST_BUSY];
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy bit stuck");

    property p_link;
        $past(presetn) |-> status_word[ST_LINK] == $past(link_cmd_enabled);
    endproperty
    a_link: assert property (p_link) else $error("link bit wrong");

    property p_alarm;
        $past(presetn) |-> status_word[ST_ALARM] == $past(alarm_flag);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm bit wrong");

    property p_motion;
        $past(presetn) |-> status_word[10:8] ==
            $past({slowing_flag, speeding_flag, current_limit_flag});
    endproperty
    a_motion: assert property (p_motion) else $error("motion bits wrong");

    property p_vlim;
        voltage_limit_flag |=> status_word[ST_VLIM];
    endproperty
    a_vlim: assert property (p_vlim) else $error("voltage limit bit wrong");

    property p_busok;
        !bus_voltage_ok |=> !status_word[ST_BUSOK];
    endproperty
    a_busok: assert property (p_busok) else $error("bus voltage bit wrong");

    property p_stop;
        $past(presetn) |-> status_word[3:2] == $past({stage_stopped_flag, dc_brake_flag});
    endproperty
    a_stop: assert property (p_stop) else $error("stop or brake bit wrong");

    property p_dir;
        $past(presetn) |-> status_word[1:0] == $past({run_backward_flag, run_ahead_flag});
    endproperty
    a_dir: assert property (p_dir) else $error("direction bits wrong");

    property p_run_digits;
        mode == MODE_RUN |=> digit_seg[3] == sdh_glyph({1'b0, $past(status_word[15:12])})
            && digit_seg[0] == sdh_glyph({1'b0, $past(status_word[3:0])});
    endproperty
    a_run_digits: assert property (p_run_digits) else $error("digit order wrong");

    // bits 14, 13, 6 and 4 are always zero, so a lower-case b can only show on digits 2 or 0
    property p_glyph_b;
        mode == MODE_RUN && status_word[11:8] == 4'hb && status_word[3:0] == 4'hd
            |=> digit_seg[2] == 7'h7c && digit_seg[0] == 7'h5e;
    endproperty
    a_glyph_b: assert property (p_glyph_b) else $error("lower-case glyph wrong");

    property p_limit;
        mode == MODE_MENU && ui.key_func && !ui.key_prog && ctrl_limit != LIMIT_FULL
            |=> mode == MODE_MENU;
    endproperty
    a_limit: assert property (p_limit) else $error("menu opened without full mode");

    property p_enter_prog;
        mode == MODE_RUN && ui.key_prog |=> mode == MODE_MENU;
    endproperty
    a_enter_prog: assert property (p_enter_prog) else $error("no programming mode");

    property p_io_dig;
        mode == MODE_ITEM && menu_no == MENU_IO && item_no == IO_DIG
            |=> digit_seg[0] == sdh_glyph({1'b0, $past(io_terminals[3:0])});
    endproperty
    a_io_dig: assert property (p_io_dig) else $error("terminal item wrong");

    property p_return;
        s_list_ret |=> mode == MODE_MENU;
    endproperty
    a_return: assert property (p_return) else $error("return path wrong");

    property p_item_ret;
        s_item_ret |=> mode == MODE_LIST;
    endproperty
    a_item_ret: assert property (p_item_ret) else $error("item return wrong");

    property p_drive_item;
        mode == MODE_ITEM && menu_no == MENU_DRIVE
            |=> digit_seg[3] == sdh_glyph({1'b0, $past(status_word[15:12])});
    endproperty
    a_drive_item: assert property (p_drive_item) else $error("status item wrong");
endmodule
`default_nettype wire

// ---- sdh_status_display_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- sdh_led_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// stands in for the four-digit led panel: turns lit segments back into glyph codes
module sdh_led_model (
    input wire sdh_pkg::sdh_seg_t [3:0] digit_seg,
    output logic [19:0] shown
);
    import sdh_pkg::*;
    // ****************************************
    // glyph recognition
    // ****************************************
    // codes 0..15 hex, 16 underscore, 17 blank, 18 dash; 5'h1f = shape not recognised
    localparam logic [6:0] SHAPES [19] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
        7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71, 7'h08, 7'h00, 7'h40};
    always_comb
    begin
        shown = '1;
        for (int d = 0; d < 4; d++)
        begin
            for (int g = 0; g < 19; g++)
            begin
                if (digit_seg[d] === SHAPES[g])
                begin
                    shown[d*5 +: 5] = 5'(g);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- sdh_status_display_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdh_status_display_tb;
    import sdh_pkg::*;
    // flags[k] drives status bit POS[k]
    localparam int POS [12] = '{0, 1, 2, 3, 5, 7, 8, 9, 10, 11, 12, 15};
    localparam logic [15:0] VALS [5] = '{16'h0123, 16'h4567, 16'h89ab, 16'hcdef, 16'hf00d};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] flags = 12'h000;
    logic [3:0] key_raw = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sdh_seg_t [3:0] digit_seg;
    logic [19:0] shown;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    always #4 pclk = ~pclk;

    sdh_status_display sdh_status_display_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_write_busy(flags[11]),
        .link_cmd_enabled(flags[10]), .alarm_flag(flags[9]), .slowing_flag(flags[8]),
        .speeding_flag(flags[7]), .current_limit_flag(flags[6]), .voltage_limit_flag(flags[5]),
        .bus_voltage_ok(flags[4]), .stage_stopped_flag(flags[3]), .dc_brake_flag(flags[2]),
        .run_backward_flag(flags[1]), .run_ahead_flag(flags[0]), .io_terminals(VALS[0]),
        .link_terminals(VALS[1]), .voltage_analog_in(VALS[2]), .current_analog_in(VALS[3]),
        .meter_analog_out(VALS[4]), .key_raw(key_raw), .digit_seg(digit_seg));
    sdh_led_model sdh_led_model_inst (.digit_seg(digit_seg), .shown(shown));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic close_out;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // a generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            close_out();
        end
    end

    // ****************************************
    // bus and key drivers
    // ****************************************
    // entered just after a rising edge; leaves one idle edge so psel is never set twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rdat, exp);
        chk("pslverr", {31'h0, rerr}, {31'h0, err});
    endtask

    // held and released well past the synchroniser and edge detector
    task automatic press(input int k);
        key_raw[k] <= 1'b1;
        repeat (5) @(posedge pclk);
        key_raw[k] <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    function automatic logic [19:0] hx(input logic [15:0] v);
        return {1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
    endfunction

    task automatic see(input logic [19:0] exp, input string n);
        repeat (3) @(posedge pclk);
        chk(n, {12'h0, shown}, {12'h0, exp});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(ADDR_UI, 32'h010, 1'b0, "mode after reset");
        for (int k = 0; k < 12; k++)
        begin
            flags <= 12'h001 << k;
            repeat (2) @(posedge pclk);
            rdchk(ADDR_STATUS, 32'h1 << POS[k], 1'b0, "status bit");
        end
        flags <= 12'hfff;
        repeat (2) @(posedge pclk);
        rdchk(ADDR_STATUS, 32'h9faf, 1'b0, "status all set");
        see(hx(16'h9faf), "run digits");
        flags <= 12'h000;
        repeat (2) @(posedge pclk);
        rdchk(ADDR_STATUS, 32'h0, 1'b0, "status cleared");
        flags <= 12'h2cd;
        see(hx(16'h0b0d), "lower-case digits");
        rdchk(12'h010, 32'h0, 1'b1, "unmapped read");
        press(0);
        rdchk(ADDR_UI, 32'h110, 1'b0, "menu entry");
        see({5'h01, GLY_UNDER, GLY_DASH, GLY_DASH}, "menu digits");
        repeat (3) press(2);
        press(1);
        rdchk(ADDR_UI, 32'h140, 1'b0, "io menu locked");
        apb(1'b1, ADDR_CTRL, {30'h0, LIMIT_FULL});
        press(1);
        rdchk(ADDR_UI, 32'h240, 1'b0, "io list");
        see({5'h04, GLY_UNDER, 5'h00, 5'h00}, "list digits");
        for (int i = 0; i < 5; i++)
        begin
            press(1);
            rdchk(ADDR_UI, 32'h340 + i, 1'b0, "io item");
            see(hx(VALS[i]), "item digits");
            press(0);
            rdchk(ADDR_UI, 32'h240 + i, 1'b0, "back to list");
            press(2);
        end
        press(0);
        rdchk(ADDR_UI, 32'h140, 1'b0, "back to menu");
        press(3);
        press(1);
        press(1);
        rdchk(ADDR_UI, 32'h337, 1'b0, "drive status item");
        flags <= 12'h0a5;
        see(hx(16'h0285), "drive status digits");
        close_out();
    end
endmodule
`default_nettype wire
